// ===== hdl/t2pwm_pkg.sv
// constants shared by the timer 2 pwm, baud and clock-out block
`default_nettype none
package t2pwm_pkg;
	// special-function register addresses
	localparam logic [7:0] ADDR_CTRL   = 8'hc8;
	localparam logic [7:0] ADDR_MODE   = 8'hc9;
	localparam logic [7:0] ADDR_MODE_B = 8'h93;
	localparam logic [7:0] ADDR_RLD_L  = 8'hca;
	localparam logic [7:0] ADDR_RLD_H  = 8'hcb;
	localparam logic [7:0] ADDR_CNT_L  = 8'hcc;
	localparam logic [7:0] ADDR_CNT_H  = 8'hcd;
	// control register bits
	localparam int C_OVF  = 7;
	localparam int C_EXF  = 6;
	localparam int C_RXS  = 5;
	localparam int C_TXS  = 4;
	localparam int C_FEN  = 3;
	localparam int C_RUN  = 2;
	localparam int C_CNT  = 1;
	localparam int C_CPRL = 0;
	// mode register bits
	localparam int M_SPL  = 7;
	localparam int M_B6   = 6;
	localparam int M_REN  = 5;
	localparam int M_X12  = 4;
	localparam int M_LRUN = 3;
	localparam int M_LRC  = 2;
	localparam int M_OE   = 1;
	localparam int M_MS0  = 0;
	// second mode register bits
	localparam int B_LCS  = 7;
	localparam int B_IG   = 6;
	localparam int B_ALS  = 5;
	localparam int B_CKS  = 4;
	localparam int B_MS1  = 3;
	// mode code {ms_hi, cp/rl, ms_lo} of split pwm
	localparam logic [2:0] MODE_PWM = 3'h4;
	// reset value of every register, and the byte rollover point
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	// system clock divided by twelve source
	localparam int PRESCALE = 12;
	localparam logic [3:0] DIV_LAST = 4'(PRESCALE - 1);
endpackage
`default_nettype wire

// ===== hdl/t2pwm_timer2.sv
// timer 2 pwm, baud generator and clock-out logic behind the sfr port
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R01] split pwm: high byte auto-reloads, sets period
// [R02] low byte compares; overflow flags, loads low
// [R03] pwm reaches pin only with clock-out enable
// [R04] pwm high while high byte below compare
// [R05] receive clock from timer2 in uart 1/3
// [R06] transmit clock from timer2 or timer1 independently
// [R07] baud mode: rollover reloads full sixteen bits
// [R08] baud mode falling edge flags, never reloads
// [R09] overflow sets flag; ignore bit blocks request
// [R10] software stops timer before touching counters
// [R11] split baud: low byte baud, high auto-reload
// [R12] clock-out gives half duty clock on pin
// [R13] clock-out overflow reloads counters and toggles
// [R14] software configures reload, counter, enable, run
// [R15] baud and clock-out share one overflow
// [R16] split clock-out toggles on low overflow
// [R17] software sets low source before low run
// [R18] low overflow flag, enable requests shared vector
// [R19] enabled trigger edges set external edge flag
// [R20] serial use still reports trigger edges
// [R21] run bit starts/stops; split: high only
// [R22] control bits 5/4 aliased by alias select
// [R23] split pwm selected by mode code 100
// [R24] clock-out enable sits in mode bit 1
module t2pwm_timer2 (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr_en,
	input  wire logic       sfr_rd_en,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       external_trigger_input,
	input  wire logic       t2_count_pin,
	input  wire logic       int0_evt,
	input  wire logic [3:0] periph_evt,
	input  wire logic       timer1_ovf,
	input  wire logic       uart_mode13,
	output logic            clock_out_pin,
	output logic            rx_baud_tick,
	output logic            tx_baud_tick,
	output logic            timer2_irq
);
	// register state
	logic [7:0] ctrl_ff, nxt_ctrl;       // bits 5/4 hold the baud selects
	logic [7:0] mode_ff, nxt_mode;       // bit 6 holds the low clock x12
	logic [7:0] modeb_ff, nxt_modeb;
	logic [1:0] alt_ff, nxt_alt;         // {low_overflow_flag, low irq enable}
	logic       eip_ff, nxt_eip;         // trigger inversion behind bit 6
	logic [7:0] cnt_h_ff, nxt_cnt_h;
	logic [7:0] cnt_l_ff, nxt_cnt_l;
	logic [7:0] rld_h_ff, nxt_rld_h;
	logic [7:0] rld_l_ff, nxt_rld_l;
	logic [3:0] div_ff, nxt_div;         // divide by twelve prescaler
	logic       tgl_ff, nxt_tgl;         // clock-out toggle
	logic [7:0] rdata_ff, nxt_rdata;
	logic       pin_ff, nxt_pin;
	logic       rx_ff, nxt_rx;
	logic       tx_ff, nxt_tx;
	logic       irq_ff, nxt_irq;
	// pin synchronisers; stage a is read only by stage b
	logic [1:0] trg_a_ff, trg_b_ff;
	logic       trg_d_ff, cpin_d_ff;
	// decoded helpers
	logic       split, pwm_mode, baud, clkout16, pwm_below;
	logic       tick_h, tick_l, div_tick, cpin_fall;
	logic       trg_lvl, trg_rise, trg_fall, edge_set;
	logic       t2of, h_ovf, l_ovf, ovf_ev, tf2_set;
	logic [2:0] hsrc, msel;
	logic [1:0] lsrc;

	// two-flop synchronisers, then a delayed copy for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trg_a_ff  <= 2'h0;
			trg_b_ff  <= 2'h0;
			trg_d_ff  <= 1'b0;
			cpin_d_ff <= 1'b0;
		end else begin
			trg_a_ff  <= {t2_count_pin, external_trigger_input};
			trg_b_ff  <= trg_a_ff;
			trg_d_ff  <= trg_lvl;
			cpin_d_ff <= trg_b_ff[1];
		end
	end

	// mode decode and source selection
	always_comb begin
		split     = mode_ff[t2pwm_pkg::M_SPL];
		msel      = {modeb_ff[t2pwm_pkg::B_MS1], ctrl_ff[t2pwm_pkg::C_CPRL],
		             mode_ff[t2pwm_pkg::M_MS0]};
		pwm_mode  = split && (msel == t2pwm_pkg::MODE_PWM); // R23
		baud      = ctrl_ff[t2pwm_pkg::C_RXS] | ctrl_ff[t2pwm_pkg::C_TXS]; // R07
		// sixteen-bit clock-out needs the auto-reload setting
		clkout16  = !split && !ctrl_ff[t2pwm_pkg::C_CPRL]; // R12
		pwm_below = cnt_h_ff < cnt_l_ff; // R04
		div_tick  = div_ff == t2pwm_pkg::DIV_LAST;
		cpin_fall = cpin_d_ff && !trg_b_ff[1];
		trg_lvl   = trg_b_ff[0] ^ eip_ff;
		trg_rise  = trg_lvl && !trg_d_ff;
		trg_fall  = !trg_lvl && trg_d_ff;
		hsrc      = {modeb_ff[t2pwm_pkg::B_CKS], mode_ff[t2pwm_pkg::M_X12],
		             ctrl_ff[t2pwm_pkg::C_CNT]};
		lsrc      = {modeb_ff[t2pwm_pkg::B_LCS], mode_ff[t2pwm_pkg::M_B6]};
		case (lsrc)
			2'h0:    tick_l = div_tick;
			2'h1:    tick_l = 1'b1;
			2'h2:    tick_l = periph_evt[0];
			default: tick_l = int0_evt;
		endcase
		case (hsrc)
			3'h0:    tick_h = div_tick;
			3'h1:    tick_h = cpin_fall;
			3'h2:    tick_h = 1'b1;
			3'h3:    tick_h = int0_evt;
			default: tick_h = periph_evt[hsrc[1:0]];
		endcase
	end

	// counting, flags, register writes and reads: next values
	always_comb begin
		nxt_ctrl  = ctrl_ff;
		nxt_mode  = mode_ff;
		nxt_modeb = modeb_ff;
		nxt_alt   = alt_ff;
		nxt_eip   = eip_ff;
		nxt_cnt_h = cnt_h_ff;
		nxt_cnt_l = cnt_l_ff;
		nxt_rld_h = rld_h_ff;
		nxt_rld_l = rld_l_ff;
		nxt_div   = div_tick ? 4'h0 : div_ff + 4'h1;
		t2of      = 1'b0;
		h_ovf     = 1'b0;
		l_ovf     = 1'b0;
		// the low byte counts on its own in split mode only, so it may tick on
		// its own source; in sixteen-bit mode both bytes share tick_h
		if (!split) begin
			if (ctrl_ff[t2pwm_pkg::C_RUN] && tick_h) begin // R21
				if ({cnt_h_ff, cnt_l_ff} == {t2pwm_pkg::BYTE_MAX, t2pwm_pkg::BYTE_MAX}) begin
					t2of = 1'b1;
					// baud and auto-reload both reload; edges never do
					nxt_cnt_h = rld_h_ff; // R07 R13
					nxt_cnt_l = rld_l_ff; // R07 R13
				end else begin
					{nxt_cnt_h, nxt_cnt_l} = {cnt_h_ff, cnt_l_ff} + 16'h0001;
				end
			end
		end else begin
			if (ctrl_ff[t2pwm_pkg::C_RUN] && tick_h) begin // R21
				if (cnt_h_ff == t2pwm_pkg::BYTE_MAX) begin
					h_ovf     = 1'b1;
					nxt_cnt_h = rld_h_ff; // R01 R11
					if (pwm_mode) begin
						nxt_cnt_l = rld_l_ff; // R02
					end
					if (mode_ff[t2pwm_pkg::M_LRC]) begin
						nxt_mode[t2pwm_pkg::M_LRUN] = 1'b0;
					end
				end else begin
					nxt_cnt_h = cnt_h_ff + 8'h01;
				end
			end
			// in pwm mode the low byte only holds the compare value
			if (!pwm_mode && mode_ff[t2pwm_pkg::M_LRUN] && tick_l) begin
				if (cnt_l_ff == t2pwm_pkg::BYTE_MAX) begin
					l_ovf     = 1'b1;
					nxt_cnt_l = rld_l_ff; // R11 R16
				end else begin
					nxt_cnt_l = cnt_l_ff + 8'h01;
				end
			end
		end
		// split mode replaces the timer overflow by the low overflow
		ovf_ev  = split ? l_ovf : t2of; // R15 R11
		// flag is set in baud mode too, so the ignore bit is the way out
		tf2_set = split ? h_ovf : t2of; // R09 R15
		// trigger edges only flag; capture and reload are not served
		edge_set = (trg_fall && ctrl_ff[t2pwm_pkg::C_FEN]) ||
		           (trg_rise && mode_ff[t2pwm_pkg::M_REN]); // R08 R19 R20
		nxt_tgl = tgl_ff ^ (ovf_ev && (split || clkout16)); // R13 R16
		// software writes; hardware counting gives way to them
		if (sfr_wr_en) begin
			if (sfr_addr == t2pwm_pkg::ADDR_CTRL) begin
				nxt_ctrl = sfr_wdata;
				if (modeb_ff[t2pwm_pkg::B_ALS]) begin // R22
					nxt_ctrl[t2pwm_pkg::C_RXS] = ctrl_ff[t2pwm_pkg::C_RXS];
					nxt_ctrl[t2pwm_pkg::C_TXS] = ctrl_ff[t2pwm_pkg::C_TXS];
					nxt_alt = sfr_wdata[t2pwm_pkg::C_RXS:t2pwm_pkg::C_TXS];
				end
			end else if (sfr_addr == t2pwm_pkg::ADDR_MODE) begin
				nxt_mode = sfr_wdata; // R24
				if (modeb_ff[t2pwm_pkg::B_ALS]) begin
					nxt_mode[t2pwm_pkg::M_B6] = mode_ff[t2pwm_pkg::M_B6];
					nxt_eip = sfr_wdata[t2pwm_pkg::M_B6];
				end
			end else if (sfr_addr == t2pwm_pkg::ADDR_MODE_B) begin
				nxt_modeb = sfr_wdata;
			end else if (sfr_addr == t2pwm_pkg::ADDR_RLD_L) begin
				nxt_rld_l = sfr_wdata;
			end else if (sfr_addr == t2pwm_pkg::ADDR_RLD_H) begin
				nxt_rld_h = sfr_wdata;
			end else if (sfr_addr == t2pwm_pkg::ADDR_CNT_L) begin
				nxt_cnt_l = sfr_wdata;
			end else if (sfr_addr == t2pwm_pkg::ADDR_CNT_H) begin
				nxt_cnt_h = sfr_wdata;
			end
		end
		// hardware set wins over a software clear in the same cycle
		nxt_ctrl[t2pwm_pkg::C_OVF] = nxt_ctrl[t2pwm_pkg::C_OVF] | tf2_set; // R09
		nxt_ctrl[t2pwm_pkg::C_EXF] = nxt_ctrl[t2pwm_pkg::C_EXF] | edge_set; // R19
		nxt_alt[1] = nxt_alt[1] | l_ovf; // R18
		// pwm level or toggle, gated by the clock-out enable
		nxt_pin = mode_ff[t2pwm_pkg::M_OE] && // R03
		          (pwm_mode ? pwm_below : (split || clkout16) && tgl_ff); // R04 R12
		// baud clock sources, each selected on its own
		nxt_rx = ctrl_ff[t2pwm_pkg::C_RXS] ? ovf_ev && uart_mode13 : timer1_ovf; // R05
		nxt_tx = ctrl_ff[t2pwm_pkg::C_TXS] ? ovf_ev : timer1_ovf; // R06
		nxt_irq = (ctrl_ff[t2pwm_pkg::C_OVF] && !modeb_ff[t2pwm_pkg::B_IG]) ||
		          ctrl_ff[t2pwm_pkg::C_EXF] || (alt_ff[1] && alt_ff[0]); // R09 R18
		// read mux; unmapped addresses read zero, data holds otherwise
		nxt_rdata = rdata_ff;
		if (sfr_rd_en) begin
			if (sfr_addr == t2pwm_pkg::ADDR_CTRL) begin
				nxt_rdata = ctrl_ff;
				if (modeb_ff[t2pwm_pkg::B_ALS]) begin
					nxt_rdata[t2pwm_pkg::C_RXS:t2pwm_pkg::C_TXS] = alt_ff; // R22
				end
			end else if (sfr_addr == t2pwm_pkg::ADDR_MODE) begin
				nxt_rdata = mode_ff;
				if (modeb_ff[t2pwm_pkg::B_ALS]) begin
					nxt_rdata[t2pwm_pkg::M_B6] = eip_ff;
				end
			end else if (sfr_addr == t2pwm_pkg::ADDR_MODE_B) begin
				nxt_rdata = modeb_ff;
			end else if (sfr_addr == t2pwm_pkg::ADDR_RLD_L) begin
				nxt_rdata = rld_l_ff;
			end else if (sfr_addr == t2pwm_pkg::ADDR_RLD_H) begin
				nxt_rdata = rld_h_ff;
			end else if (sfr_addr == t2pwm_pkg::ADDR_CNT_L) begin
				nxt_rdata = cnt_l_ff;
			end else if (sfr_addr == t2pwm_pkg::ADDR_CNT_H) begin
				nxt_rdata = cnt_h_ff;
			end else begin
				nxt_rdata = t2pwm_pkg::RST_BYTE;
			end
		end
	end

	// register stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff  <= t2pwm_pkg::RST_BYTE;
			mode_ff  <= t2pwm_pkg::RST_BYTE;
			modeb_ff <= t2pwm_pkg::RST_BYTE;
			alt_ff   <= 2'h0;
			eip_ff   <= 1'b0;
			cnt_h_ff <= t2pwm_pkg::RST_BYTE;
			cnt_l_ff <= t2pwm_pkg::RST_BYTE;
			rld_h_ff <= t2pwm_pkg::RST_BYTE;
			rld_l_ff <= t2pwm_pkg::RST_BYTE;
			div_ff   <= 4'h0;
			tgl_ff   <= 1'b0;
			rdata_ff <= t2pwm_pkg::RST_BYTE;
			pin_ff   <= 1'b0;
			rx_ff    <= 1'b0;
			tx_ff    <= 1'b0;
			irq_ff   <= 1'b0;
		end else begin
			ctrl_ff  <= nxt_ctrl;
			mode_ff  <= nxt_mode;
			modeb_ff <= nxt_modeb;
			alt_ff   <= nxt_alt;
			eip_ff   <= nxt_eip;
			cnt_h_ff <= nxt_cnt_h;
			cnt_l_ff <= nxt_cnt_l;
			rld_h_ff <= nxt_rld_h;
			rld_l_ff <= nxt_rld_l;
			div_ff   <= nxt_div;
			tgl_ff   <= nxt_tgl;
			rdata_ff <= nxt_rdata;
			pin_ff   <= nxt_pin;
			rx_ff    <= nxt_rx;
			tx_ff    <= nxt_tx;
			irq_ff   <= nxt_irq;
		end
	end

	assign sfr_rdata     = rdata_ff;
	assign clock_out_pin = pin_ff;
	assign rx_baud_tick  = rx_ff;
	assign tx_baud_tick  = tx_ff;
	assign timer2_irq    = irq_ff;

	// checks on the design's own outputs and state
	pwm_level_a: assert property (@(posedge clk) disable iff (!rst_n) // R04
		pwm_mode && mode_ff[t2pwm_pkg::M_OE] |=> clock_out_pin == $past(pwm_below))
		else $error("pwm level does not follow compare");
	pin_gated_a: assert property (@(posedge clk) disable iff (!rst_n) // R03
		!mode_ff[t2pwm_pkg::M_OE] |=> !clock_out_pin)
		else $error("clock pin driven while disabled");
	ovf_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R09
		tf2_set |=> ctrl_ff[t2pwm_pkg::C_OVF] ##1 ctrl_ff[t2pwm_pkg::C_OVF] || timer2_irq
		|| modeb_ff[t2pwm_pkg::B_IG])
		else $error("overflow flag or request missing");
	brg_reload_a: assert property (@(posedge clk) disable iff (!rst_n) // R07
		!split && baud && t2of && !sfr_wr_en |=>
		{cnt_h_ff, cnt_l_ff} == {$past(rld_h_ff), $past(rld_l_ff)})
		else $error("baud reload wrong");
	pwm_load_a: assert property (@(posedge clk) disable iff (!rst_n) // R02
		pwm_mode && h_ovf && !sfr_wr_en |=> cnt_l_ff == $past(rld_l_ff))
		else $error("compare not loaded on overflow");
	tx_source_a: assert property (@(posedge clk) disable iff (!rst_n) // R06
		ctrl_ff[t2pwm_pkg::C_TXS] |=> tx_baud_tick == $past(ovf_ev))
		else $error("transmit tick not from timer 2");
	clk_toggle_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
		clkout16 && t2of |=> tgl_ff != $past(tgl_ff))
		else $error("clock-out did not toggle");
	edge_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R08
		trg_fall && ctrl_ff[t2pwm_pkg::C_FEN] |=> ctrl_ff[t2pwm_pkg::C_EXF])
		else $error("falling edge not flagged");
	run_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // R21
		!ctrl_ff[t2pwm_pkg::C_RUN] && !sfr_wr_en |=> $stable(cnt_h_ff))
		else $error("high byte moved while stopped");
	low_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
		l_ovf |=> alt_ff[1])
		else $error("low overflow not flagged");
	pwm_run_c: cover property (@(posedge clk) disable iff (!rst_n)
		pwm_mode && h_ovf ##[1:300] $fell(clock_out_pin));
	clkout_c: cover property (@(posedge clk) disable iff (!rst_n) clkout16 && t2of);
	split_ovf_c: cover property (@(posedge clk) disable iff (!rst_n) l_ovf && rx_ff);
	baud_c: cover property (@(posedge clk) disable iff (!rst_n) baud && tx_baud_tick);
endmodule // t2pwm_timer2
`default_nettype wire

// ===== tb/t2pwm_uart_model.sv
// serial port engine model that consumes the receive and transmit baud ticks
`timescale 1ns/100ps
`default_nettype none
module t2pwm_uart_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic rx_baud_tick,
	input  wire logic tx_baud_tick,
	input  wire logic mode13_sel,
	output logic      uart_mode13,
	output var int    rx_cnt,
	output var int    tx_cnt
);
	// frame mode 1 or 3 is a plain level taken from the mode13_sel input
	assign uart_mode13 = mode13_sel;
	// count each tick once; a tick held two cycles would count twice and show up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt <= 0;
			tx_cnt <= 0;
		end else begin
			rx_cnt <= rx_cnt + int'(rx_baud_tick === 1'b1);
			tx_cnt <= tx_cnt + int'(tx_baud_tick === 1'b1);
		end
	end
endmodule // t2pwm_uart_model
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the timer 2 pwm, baud and clock-out block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [7:0] CTRL = t2pwm_pkg::ADDR_CTRL;
	localparam logic [7:0] MODE = t2pwm_pkg::ADDR_MODE;
	localparam logic [7:0] MODB = t2pwm_pkg::ADDR_MODE_B;
	logic       clk, rst_n, wr_en, rd_en, trig, t1_ovf, m13_sel, m13;
	logic [7:0] addr, wdata, rdata;
	logic       pin, rx_tk, tx_tk, irq;
	logic       rd_d = 1'b0;         // a read was taken last edge
	logic [7:0] exp_q [$];           // expected read data, oldest first
	int         rx_cnt, tx_cnt, hi_n, rise_n, rx_n, tx_n, cyc, r, tx0;
	int         err_total = 0;
	int         cmp_count = 0;
	t2pwm_timer2 t2pwm_timer2_inst (.clk(clk), .rst_n(rst_n), .sfr_addr(addr),
		.sfr_wr_en(wr_en), .sfr_rd_en(rd_en), .sfr_wdata(wdata), .sfr_rdata(rdata),
		.external_trigger_input(trig), .t2_count_pin(1'b0), .int0_evt(1'b0),
		.periph_evt(4'h0), .timer1_ovf(t1_ovf), .uart_mode13(m13),
		.clock_out_pin(pin), .rx_baud_tick(rx_tk), .tx_baud_tick(tx_tk), .timer2_irq(irq));
	t2pwm_uart_model t2pwm_uart_model_inst (.clk(clk), .rst_n(rst_n), .rx_baud_tick(rx_tk),
		.tx_baud_tick(tx_tk), .mode13_sel(m13_sel), .uart_mode13(m13),
		.rx_cnt(rx_cnt), .tx_cnt(tx_cnt));
	// 200 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] act, input logic [31:0] exp);
		cmp_count++;
		if (act !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, act, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one write strobe; a gap cycle keeps the strobe from being set twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(posedge clk);
		#1 wr_en = 1'b0;
	endtask
	// one read strobe; the monitor compares the data a cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 addr = a;
		rd_en = 1'b1;
		exp_q.push_back(d);
		@(posedge clk);
		#1 rd_en = 1'b0;
	endtask
	// software loads reload bytes first, then the same value into the counter
	task automatic load(input logic [15:0] v);
		wr(t2pwm_pkg::ADDR_RLD_L, v[7:0]);
		wr(t2pwm_pkg::ADDR_RLD_H, v[15:8]);
		wr(t2pwm_pkg::ADDR_CNT_L, v[7:0]);
		wr(t2pwm_pkg::ADDR_CNT_H, v[15:8]);
	endtask
	// settle, then count pin highs, pin rises and ticks over n cycles;
	// samples are taken just after each edge, once the outputs have settled
	task automatic meas(input int n);
		int   a;
		int   b;
		logic last;
		repeat (8) @(posedge clk);
		#1;
		a = rx_cnt;
		b = tx_cnt;
		hi_n = 0;
		rise_n = 0;
		last = pin;
		repeat (n) begin
			@(posedge clk);
			#1;
			hi_n += int'(pin === 1'b1);
			rise_n += int'(pin === 1'b1 && last === 1'b0);
			last = pin;
		end
		rx_n = rx_cnt - a;
		tx_n = tx_cnt - b;
	endtask
	// read data checker: takes the oldest note whenever read data is due
	always @(posedge clk) begin
		if (rd_d) chk({24'h0, rdata}, {24'h0, exp_q.pop_front()});
		rd_d <= rd_en;
	end
	// hang guard, far above the eight hundred or so cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		{rst_n, wr_en, rd_en, addr, wdata, t1_ovf} = '0;
		trig = 1'b1;
		m13_sel = 1'b1;
		r = $urandom(32'h88b4c324);
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		// reset values, then an unmapped place that must stay silent
		rd(CTRL, 8'h00);
		rd(MODE, 8'h00);
		rd(MODB, 8'h00);
		rd(t2pwm_pkg::ADDR_CNT_H, 8'h00);
		wr(8'h80, 8'hff);
		rd(8'h80, 8'h00);
		r = $urandom;
		wr(t2pwm_pkg::ADDR_RLD_L, r[7:0]);
		rd(t2pwm_pkg::ADDR_RLD_L, r[7:0]);
		wr(t2pwm_pkg::ADDR_RLD_H, r[15:8]);
		rd(t2pwm_pkg::ADDR_RLD_H, r[15:8]);
		// baud mode on the full system clock: one overflow every 2 cycles
		wr(MODE, 8'h10);
		load(16'hfffe);
		wr(CTRL, 8'h34);
		meas(40);
		chk(rx_n, 20);
		chk(tx_n, 20);
		// receive still timer 2 but engine out of mode 1/3; transmit from timer 1
		m13_sel = 1'b0;
		wr(CTRL, 8'h2c);
		meas(4);
		r = rx_cnt;
		tx0 = tx_cnt;
		repeat (5) begin
			@(posedge clk);
			#1 t1_ovf = 1'b1;
			@(posedge clk);
			#1 t1_ovf = 1'b0;
		end
		trig = 1'b0;
		meas(4);
		chk(rx_cnt - r, 0);
		chk(tx_cnt - tx0, 5);
		rd(CTRL, 8'hec);
		// overflow flag request, then blocked by the ignore bit
		wr(CTRL, 8'h80);
		meas(2);
		chk(irq, 1);
		wr(MODB, 8'h40);
		meas(2);
		chk(irq, 0);
		// aliased bits reach the low flag and enable, with separate storage
		wr(MODB, 8'h60);
		wr(CTRL, 8'h30);
		rd(CTRL, 8'h30);
		meas(2);
		chk(irq, 1);
		wr(MODB, 8'h40);
		rd(CTRL, 8'h00);
		wr(MODB, 8'h60);
		wr(CTRL, 8'h00);
		wr(MODB, 8'h00);
		// 16-bit clock-out: 4 counts per overflow, period 2 x 4 cycles
		wr(MODE, 8'h12);
		load(16'hfffc);
		wr(CTRL, 8'h04);
		meas(80);
		chk(rise_n, 10);
		chk(hi_n, 40);
		// split pwm: period 16 counts, high while counter below 0xf8
		wr(CTRL, 8'h00);
		wr(MODB, 8'h08);
		wr(MODE, 8'h92);
		load(16'hf0f8);
		wr(CTRL, 8'h04);
		meas(160);
		chk(hi_n, 80);
		rd(CTRL, 8'h84);
		// a new compare waits in the low reload byte until the next overflow
		wr(t2pwm_pkg::ADDR_RLD_L, 8'hf4);
		repeat (16) @(posedge clk);
		meas(160);
		chk(hi_n, 40);
		wr(MODE, 8'h90);
		meas(48);
		chk(hi_n, 0);
		// split clock-out and baud on the low byte: one overflow every 3 cycles
		wr(CTRL, 8'h00);
		wr(CTRL, 8'h30);
		wr(MODB, 8'h00);
		m13_sel = 1'b1;
		wr(MODE, 8'hc0);
		wr(t2pwm_pkg::ADDR_RLD_L, 8'hfd);
		wr(t2pwm_pkg::ADDR_CNT_L, 8'hfd);
		wr(MODE, 8'hc2);
		wr(MODE, 8'hca);
		meas(60);
		chk(rise_n, 10);
		chk(hi_n, 30);
		chk(tx_n, 20);
		chk(rx_n, 20);
		// low flag seen through the alias, then its request once enabled
		wr(MODB, 8'h20);
		rd(CTRL, 8'h20);
		wr(CTRL, 8'h10);
		meas(2);
		chk(irq, 1);
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
